/* File: hw/level_sync.sv */
// Two-flop synchroniser for slow levels entering a clock domain
`timescale 1ns/10ps
`default_nettype none

module level_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic clear,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // First stage feeds only the second stage
   logic [WIDTH-1:0] meta;

   // Each bit is crossed on its own, so only levels go through here
   always_ff @(posedge clk)
   begin
      if (clear)
      begin
         meta <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

/* File: hw/paged_spi_register_access.sv */
// Serial configuration port: frame shifter, page pointer and decode
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Frames are 24 bits: control, address, data
// - Capture on rising edges, drive readback on falling
// - Seven digital pages reached through the pointer
// - Pointer bytes at 002h, 003h, 004h
// - Pointer 61/ch/00 selects offset corrector page
// - Pointer 61/ch/05 selects digital gain page
// - Pointer 68/ch/00 selects main digital page
// - Pointer 69/00/00 selects shared link page
// - Bank and page bits set access page register
// - Link page: channel bit 0 is B, 1 is A
// - Readback returns page register on read-out pin, or on write-in pin in three-wire mode
// - Page stays selected across any number of reads
// - Decimation and detector pages addressed directly
// - A10 picks page, A11 picks channel
// - Decimation write 02h to 001h forwarded unchanged
module paged_spi_register_access
   import paged_spi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic shift_clk,
   input wire logic serial_select_low,
   input wire logic serial_write_in,
   output logic serial_write_out,
   output logic serial_write_oe,
   output logic serial_read_out,
   output page_access_s page_access,
   output logic page_access_valid,
   input wire logic [7:0] page_read_data,
   output logic [23:0] page_pointer,
   output logic three_wire_mode,
   output logic master_page_selected,
   output logic converter_page_selected,
   output logic sysref_power_down,
   output logic global_power_down,
   output logic soft_reset_pulse
);

   // ---------------- Link domain (shift_clk) ----------------

   logic [4:0] bit_count; // Bits taken so far in this frame
   logic [22:0] shift_in; // Bits taken so far, newest at the bottom
   logic [15:0] next_cmd; // Command word as it completes
   frame_s frame; // Last frame, held stable for the ref side
   logic word_ready; // Write frame complete, level until deselect
   logic read_req; // Read command complete, level until deselect
   logic [7:0] out_shift; // Readback byte, MSB goes out first
   logic driving; // Readback in progress on this frame
   logic three_wire_link; // Wire mode as seen by the link side
   logic [7:0] read_hold; // Readback byte prepared by the ref side

   // Command word as it stands at the sixteenth rising edge
   assign next_cmd = {shift_in[14:0], serial_write_in};

   // Bit counter and input shifter; deselect ends the frame at once
   always_ff @(posedge shift_clk or posedge serial_select_low)
   begin
      if (serial_select_low)
      begin
         bit_count <= 5'h00;
         shift_in <= 23'h000000;
      end
      else
      begin
         if (bit_count != FRAME_BITS)
            bit_count <= bit_count + 5'h01;
         shift_in <= {shift_in[21:0], serial_write_in};
      end
   end

   // Frame capture; no reset so the ref side sees a stable copy
   always_ff @(posedge shift_clk)
   begin
      if (bit_count == CMD_BITS - 5'h01)
         {frame.read, frame.bank, frame.page_or_reg, frame.chan,
          frame.addr} <= next_cmd;
      if (bit_count == FRAME_BITS - 5'h01)
         frame.data <= {shift_in[6:0], serial_write_in};
   end

   // Completion levels; cleared by deselect so each frame is one event
   always_ff @(posedge shift_clk or posedge serial_select_low)
   begin
      if (serial_select_low)
      begin
         word_ready <= 1'b0;
         read_req <= 1'b0;
      end
      else
      begin
         if (bit_count == FRAME_BITS - 5'h01 && !frame.read)
            word_ready <= 1'b1;
         if (bit_count == CMD_BITS - 5'h01 && next_cmd[15])
            read_req <= 1'b1;
      end
   end

   // Readback shifter on falling edges. read_hold is a word from the
   // ref side: it is safe only because the host pauses the shift
   // clock after the address, so the word has long settled here.
   always_ff @(negedge shift_clk or posedge serial_select_low)
   begin
      if (serial_select_low)
      begin
         out_shift <= 8'h00;
         driving <= 1'b0;
      end
      else if (bit_count == CMD_BITS && read_req && !driving)
      begin
         out_shift <= read_hold;
         driving <= 1'b1;
      end
      else
         out_shift <= {out_shift[6:0], 1'b0};
   end

   // Wire mode is static during frames; crossed as a plain level
   level_sync #(.WIDTH(1)) wire_mode_sync (
      .clk(shift_clk),
      .clear(1'b0),
      .async_in(three_wire_mode),
      .sync_out(three_wire_link)
   );

   // Pin drive: four-wire uses the read-out pin, three-wire turns
   // the write-in pin around while readback runs
   assign serial_read_out = driving & ~three_wire_link & out_shift[7];
   assign serial_write_out = out_shift[7];
   assign serial_write_oe = driving & three_wire_link;

   // ---------------- Register domain (ref_clk) ----------------

   logic word_seen; // Synchronised write completion
   logic read_seen; // Synchronised read completion
   logic word_prev; // Previous word_seen, for edge detection
   logic read_prev; // Previous read_seen, for edge detection
   logic word_go; // One-cycle: a write frame has landed
   logic read_go; // One-cycle: a read command has landed
   logic wr_go; // Write event on a write frame

   // Both completion levels come from the link domain
   level_sync #(.WIDTH(2)) done_sync (
      .clk(ref_clk),
      .clear(sys_rst),
      .async_in({word_ready, read_req}),
      .sync_out({word_seen, read_seen})
   );

   // Edge detectors on the synchronised levels
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         word_prev <= 1'b0;
         read_prev <= 1'b0;
      end
      else
      begin
         word_prev <= word_seen;
         read_prev <= read_seen;
      end
   end

   assign word_go = word_seen & ~word_prev;
   assign read_go = read_seen & ~read_prev;
   assign wr_go = word_go & ~frame.read;

   // Address space decode; the frame is stable while either level is up
   logic gen_space; // General registers reachable
   logic direct_space; // Direct decimation / detector access
   logic page_space; // Access into the pointer-selected page
   logic is_general; // Address names a general register
   logic gen_hit; // Access lands on a general register
   logic pdn_hit; // Access lands on the power-down register
   logic ptr_mid_ok; // Mid pointer byte names a channel
   page_e ptr_page; // Page named by the pointer
   page_e ext_page; // Page for a forwarded access
   logic ext_chan_b; // Forwarded access is for channel B
   logic ext_hit; // Access goes to the page logic outside

   // Pointer write cycles use bank=1, page=0, chan=0 and reach the
   // general registers just as analog-bank cycles do
   assign gen_space = ~frame.bank
                    | (~frame.page_or_reg & ~frame.chan);
   assign direct_space = frame.bank & ~frame.page_or_reg
                       & frame.chan;
   assign page_space = frame.bank & frame.page_or_reg;

   assign is_general = frame.addr == OFS_SOFT_RESET
                     || frame.addr == OFS_PTR_LOW
                     || frame.addr == OFS_PTR_MID
                     || frame.addr == OFS_PTR_HIGH
                     || frame.addr == OFS_WIRE_CFG
                     || frame.addr == OFS_CONV_SEL
                     || frame.addr == OFS_MASTER_SEL;
   assign gen_hit = gen_space & is_general;

   // The power-down register lives in the master page only
   assign pdn_hit = ~frame.bank & ~is_general
                  & frame.addr == OFS_POWER_DOWN
                  & master_page_selected;

   // Pointer decode: any other pointer value selects nothing
   assign ptr_mid_ok = page_pointer[15:8] == PTR_MID_CHAN_A
                     || page_pointer[15:8] == PTR_MID_CHAN_B;
   assign ptr_page =
      (page_pointer[23:16] == PTR_HIGH_OFS_GAIN && ptr_mid_ok
       && page_pointer[7:0] == PTR_LOW_BASE) ? PAGE_OFFSET :
      (page_pointer[23:16] == PTR_HIGH_OFS_GAIN && ptr_mid_ok
       && page_pointer[7:0] == PTR_LOW_GAIN) ? PAGE_GAIN :
      (page_pointer[23:16] == PTR_HIGH_MAIN && ptr_mid_ok
       && page_pointer[7:0] == PTR_LOW_BASE) ? PAGE_MAIN :
      (page_pointer[23:16] == PTR_HIGH_LINK
       && page_pointer[15:8] == PTR_MID_CHAN_A
       && page_pointer[7:0] == PTR_LOW_BASE) ? PAGE_LINK :
      PAGE_NONE;

   // Target page; master page wins if both analog selects are set
   assign ext_page =
      direct_space ? (frame.addr[DIRECT_PAGE_BIT] ?
                      PAGE_POWER : PAGE_DECIM) :
      page_space ? ptr_page :
      (~frame.bank & master_page_selected) ? PAGE_MASTER :
      (~frame.bank & converter_page_selected) ? PAGE_CONVERTER :
      PAGE_NONE;

   // Channel: direct uses A11, any access while the pointer names the link
   // page the channel bit, all others the pointer, so the bit is ignored there
   assign ext_chan_b =
      direct_space ? frame.addr[DIRECT_CHAN_BIT] :
      (ptr_page == PAGE_LINK) ? ~frame.chan :
      page_pointer[8];

   assign ext_hit = ~gen_hit & ~pdn_hit & (ext_page != PAGE_NONE);

   // Register write strobes
   logic soft_hit; // Soft reset requested by software
   logic clear_regs; // Return registers to defaults
   logic wr_gen; // Write to a general register
   assign wr_gen = wr_go & gen_hit;
   assign soft_hit = wr_gen & frame.addr == OFS_SOFT_RESET
                   & (frame.data[SOFT_RESET_LO_BIT]
                      | frame.data[SOFT_RESET_HI_BIT]);
   assign clear_regs = sys_rst | soft_hit;

   // Page pointer bytes; held until rewritten or reset, so one selection
   // serves any number of later writes and reads
   always_ff @(posedge ref_clk)
   begin
      if (clear_regs)
         page_pointer <= RST_PAGE_PTR;
      else if (wr_gen && frame.addr == OFS_PTR_LOW)
         page_pointer[7:0] <= frame.data;
      else if (wr_gen && frame.addr == OFS_PTR_MID)
         page_pointer[15:8] <= frame.data;
      else if (wr_gen && frame.addr == OFS_PTR_HIGH)
         page_pointer[23:16] <= frame.data;
   end

   // Analog page selects and serial wire mode
   logic [7:0] conv_sel; // Converter page select byte
   always_ff @(posedge ref_clk)
   begin
      if (clear_regs)
      begin
         conv_sel <= RST_BYTE;
         master_page_selected <= RST_BIT;
         three_wire_mode <= RST_BIT;
      end
      else if (wr_gen && frame.addr == OFS_CONV_SEL)
         conv_sel <= frame.data;
      else if (wr_gen && frame.addr == OFS_MASTER_SEL)
         master_page_selected <= frame.data[MASTER_SEL_BIT];
      else if (wr_gen && frame.addr == OFS_WIRE_CFG)
         three_wire_mode <= frame.data[WIRE_MODE_BIT];
   end

   assign converter_page_selected = conv_sel == CONV_SELECT_CODE;

   // Power-down controls in the master page
   always_ff @(posedge ref_clk)
   begin
      if (clear_regs)
      begin
         sysref_power_down <= RST_BIT;
         global_power_down <= RST_BIT;
      end
      else if (wr_go && pdn_hit)
      begin
         sysref_power_down <= frame.data[SYSREF_PDN_BIT];
         global_power_down <= frame.data[GLOBAL_POWER_DOWN_BIT];
      end
   end

   // Soft reset is announced to the rest of the device for a cycle
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         soft_reset_pulse <= 1'b0;
      else
         soft_reset_pulse <= soft_hit;
   end

   // Readback value of the registers held here
   logic [7:0] local_read; // Value of the addressed local register
   assign local_read =
      !gen_hit && !pdn_hit ? RST_BYTE :
      pdn_hit ? {3'h0, sysref_power_down, 3'h0, global_power_down} :
      frame.addr == OFS_PTR_LOW ? page_pointer[7:0] :
      frame.addr == OFS_PTR_MID ? page_pointer[15:8] :
      frame.addr == OFS_PTR_HIGH ? page_pointer[23:16] :
      frame.addr == OFS_WIRE_CFG ? {7'h00, three_wire_mode} :
      frame.addr == OFS_CONV_SEL ? conv_sel :
      frame.addr == OFS_MASTER_SEL ?
         {5'h00, master_page_selected, 2'h0} :
      RST_BYTE;

   // Forwarded access. Decimation writes such as 02h to 001h reach
   // the decimation page in this single cycle, with no pointer.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         page_access_valid <= 1'b0;
         page_access <= '0;
      end
      else
      begin
         page_access_valid <= (wr_go | read_go) & ext_hit;
         page_access.write <= ~frame.read;
         page_access.page <= ext_page;
         page_access.chan_b <= ext_chan_b;
         page_access.addr <= frame.addr;
         page_access.data <= frame.read ? RST_BYTE : frame.data;
      end
   end

   // Read sequencer: local registers answer at once, page registers
   // are asked and their answer is taken a cycle after the request
   read_state_e read_state;
   read_state_e next_read_state;

   assign next_read_state =
      (read_state == RD_IDLE && read_go && ext_hit) ? RD_ASK :
      (read_state == RD_ASK) ? RD_TAKE :
      RD_IDLE;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         read_state <= RD_IDLE;
      else
         read_state <= next_read_state;
   end

   // Readback byte; stays put until the next read so the link side
   // can load it at any point of the host's pause
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         read_hold <= RST_BYTE;
      else
      begin
         unique case (read_state)
            RD_IDLE:
            begin
               if (read_go && !ext_hit)
                  read_hold <= local_read;
            end
            RD_ASK:
            begin
               read_hold <= read_hold; // Request is on the port now
            end
            RD_TAKE:
            begin
               read_hold <= page_read_data;
            end
            default:
            begin
               read_hold <= read_hold; // Unused code, no change
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* File: include/paged_spi_pkg.sv */
// Constants and types shared by the paged serial configuration port
package paged_spi_pkg;

   // Frame length and the point where the command word is complete
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam logic [4:0] CMD_BITS = 5'h10;

   // Register offsets (12-bit register address field)
   localparam logic [11:0] OFS_SOFT_RESET = 12'h000;
   localparam logic [11:0] OFS_PTR_LOW = 12'h002;
   localparam logic [11:0] OFS_PTR_MID = 12'h003;
   localparam logic [11:0] OFS_PTR_HIGH = 12'h004;
   localparam logic [11:0] OFS_WIRE_CFG = 12'h010;
   localparam logic [11:0] OFS_CONV_SEL = 12'h011;
   localparam logic [11:0] OFS_MASTER_SEL = 12'h012;
   localparam logic [11:0] OFS_POWER_DOWN = 12'h020;

   // Field positions
   localparam int SOFT_RESET_LO_BIT = 0;
   localparam int SOFT_RESET_HI_BIT = 7;
   localparam int WIRE_MODE_BIT = 0;
   localparam int MASTER_SEL_BIT = 2;
   localparam int SYSREF_PDN_BIT = 4;
   localparam int GLOBAL_POWER_DOWN_BIT = 0;
   localparam int DIRECT_PAGE_BIT = 10;
   localparam int DIRECT_CHAN_BIT = 11;

   // Page select codes
   localparam logic [7:0] CONV_SELECT_CODE = 8'hFF;
   localparam logic [7:0] PTR_HIGH_OFS_GAIN = 8'h61;
   localparam logic [7:0] PTR_HIGH_MAIN = 8'h68;
   localparam logic [7:0] PTR_HIGH_LINK = 8'h69;
   localparam logic [7:0] PTR_MID_CHAN_A = 8'h00;
   localparam logic [7:0] PTR_MID_CHAN_B = 8'h01;
   localparam logic [7:0] PTR_LOW_BASE = 8'h00;
   localparam logic [7:0] PTR_LOW_GAIN = 8'h05;

   // Reset values
   localparam logic [23:0] RST_PAGE_PTR = 24'h000000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_BIT = 1'b0;

   // Host timing the crossing relies on, in ns, and in ref_clk cycles
   localparam int REF_CLK_NS = 100;
   localparam int READ_PAUSE_NS = 800;
   localparam int WRITE_HOLD_NS = 400;
   localparam int READ_PAUSE_CYC = (READ_PAUSE_NS + REF_CLK_NS - 1) / REF_CLK_NS;
   localparam int WRITE_HOLD_CYC = (WRITE_HOLD_NS + REF_CLK_NS - 1) / REF_CLK_NS;

   // Target of a forwarded page access
   typedef enum logic [3:0] {
      PAGE_NONE = 4'h0,
      PAGE_MASTER = 4'h1,
      PAGE_CONVERTER = 4'h2,
      PAGE_OFFSET = 4'h3,
      PAGE_GAIN = 4'h4,
      PAGE_MAIN = 4'h5,
      PAGE_LINK = 4'h6,
      PAGE_DECIM = 4'h7,
      PAGE_POWER = 4'h8
   } page_e;

   // Read sequencer states
   typedef enum logic [1:0] {
      RD_IDLE = 2'h0,
      RD_ASK = 2'h1,
      RD_TAKE = 2'h3
   } read_state_e;

   // One serial frame, first bit shifted in at the top
   typedef struct packed {
      logic read;
      logic bank;
      logic page_or_reg;
      logic chan;
      logic [11:0] addr;
      logic [7:0] data;
   } frame_s;

   // Access handed to the page logic outside this block
   typedef struct packed {
      logic write;
      page_e page;
      logic chan_b;
      logic [11:0] addr;
      logic [7:0] data;
   } page_access_s;

endpackage

/* File: sim/paged_spi_sva.sv */
// Concurrent checks on the serial port's page decode
`timescale 1ns/10ps
`default_nettype none

module paged_spi_sva
   import paged_spi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic serial_select_low,
   input wire logic serial_read_out,
   input wire logic serial_write_oe,
   input wire page_access_s page_access,
   input wire logic page_access_valid,
   input wire logic [23:0] page_pointer,
   input wire logic master_page_selected,
   input wire logic converter_page_selected,
   input wire logic soft_reset_pulse
);
   // All checks live in the register clock domain
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // Page of a live access, NONE between strobes
   page_e pg;
   assign pg = page_access_valid ? page_access.page : PAGE_NONE;

   pulse_once_a: assert property (page_access_valid |=> !page_access_valid)
      else $error("access strobe held");
   decim_pick_a: assert property (pg == PAGE_DECIM |->
      !page_access.addr[10] && page_access.chan_b == page_access.addr[11])
      else $error("bad decimation decode");
   power_pick_a: assert property (pg == PAGE_POWER |->
      page_access.addr[10] && page_access.chan_b == page_access.addr[11])
      else $error("bad detector decode");
   offset_ptr_a: assert property (pg == PAGE_OFFSET |->
      page_pointer[23:16] == 8'h61 && page_pointer[15:0] inside {16'h0000,
      16'h0100}) else $error("offset page on wrong pointer");
   gain_ptr_a: assert property (pg == PAGE_GAIN |->
      page_pointer inside {24'h610005, 24'h610105})
      else $error("gain page on wrong pointer");
   main_ptr_a: assert property (pg == PAGE_MAIN |->
      page_pointer inside {24'h680000, 24'h680100})
      else $error("main page on wrong pointer");
   link_ptr_a: assert property (pg == PAGE_LINK |->
      page_pointer == 24'h690000) else $error("link page on wrong pointer");
   master_gate_a: assert property (pg == PAGE_MASTER |->
      master_page_selected) else $error("master page not selected");
   conv_gate_a: assert property (pg == PAGE_CONVERTER |->
      converter_page_selected && !master_page_selected)
      else $error("converter page not selected");
   soft_clear_a: assert property (soft_reset_pulse |->
      ##[0:2] page_pointer == 24'h000000) else $error("pointer kept");
   idle_quiet_a: assert property (serial_select_low &&
      $past(serial_select_low) |-> !serial_read_out && !serial_write_oe)
      else $error("readback driven while idle");
endmodule

`default_nettype wire

/* File: sim/spi_host_model.sv */
// Behavioural host that shifts frames into the serial port
`timescale 1ns/10ps
`default_nettype none

module spi_host_model
   import paged_spi_pkg::*;
(
   output logic shift_clk,
   output logic serial_select_low,
   output logic host_data,
   input wire logic data_pin,
   input wire logic read_pin
);
   // Half of the 30 ns link clock period
   localparam int HALF_NS = 15;

   // Clock parked low and select high between frames
   initial
   begin
      shift_clk = 1'b0;
      // A clean rising edge of select clears the link side, which has
      // no other reset; a bare X-to-1 step at time zero may be missed
      serial_select_low = 1'b0;
      host_data = 1'b0;
      #1 serial_select_low = 1'b1;
   end

   // One frame, first bit on top; readback taken on rising edges 17..24
   task automatic xfer(input logic [23:0] f, input int nbits,
                       input logic three, output logic [7:0] rd);
      rd = 8'h00;
      serial_select_low = 1'b0;
      #50;
      for (int i = 0; i < nbits; i++)
      begin
         // Released during readback: toggle so no stale level survives
         if (f[23] && i >= 16)
            host_data = ~host_data;
         else
            host_data = f[23-i];
         #HALF_NS shift_clk = 1'b1;
         if (f[23] && i >= 16)
            rd = {rd[6:0], three ? data_pin : read_pin};
         // Device fetches the byte in the register domain meanwhile
         if (f[23] && i == 15)
            #(READ_PAUSE_NS + 100);
         #HALF_NS shift_clk = 1'b0;
      end
      #(WRITE_HOLD_NS + 100);
      serial_select_low = 1'b1;
      host_data = ~host_data;
      #(WRITE_HOLD_NS + 100);
   endtask
endmodule

`default_nettype wire

/* File: sim/test_paged_spi_register_access.sv */
// Bench for the paged serial port: frames in, decode checked
`timescale 1ns/10ps
`default_nettype none

module test_paged_spi_register_access
   import paged_spi_pkg::*;
();
   // Generous ceiling: about 1200 cycles of traffic expected
   localparam int TIMEOUT_CYC = 4000;
   localparam logic [23:0] PTRS [7] = '{24'h610000, 24'h610100,
      24'h610005, 24'h610105, 24'h680000, 24'h680100, 24'h690000};
   localparam page_e PAGES [7] = '{PAGE_OFFSET, PAGE_OFFSET, PAGE_GAIN,
      PAGE_GAIN, PAGE_MAIN, PAGE_MAIN, PAGE_LINK};
   localparam logic [7:0] DIRS [4] = '{8'h50, 8'h58, 8'h54, 8'h5C};

   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] page_read_data = 8'h00;
   wire logic shift_clk, serial_select_low, host_data, serial_write_in;
   logic serial_write_out, serial_write_oe, serial_read_out, three_wire_mode;
   logic master_page_selected, converter_page_selected, soft_reset_pulse;
   logic sysref_power_down, global_power_down, page_access_valid;
   page_access_s page_access;
   page_access_s last_acc;
   logic [23:0] page_pointer;
   logic [15:0] cmd;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int acc_count = 0;
   int pulses = 0;
   int n;

   // Shared data pin: device wins while its enable is high
   assign serial_write_in = serial_write_oe ? serial_write_out : host_data;

   paged_spi_register_access u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .shift_clk(shift_clk), .serial_select_low(serial_select_low),
      .serial_write_in(serial_write_in), .serial_write_out(serial_write_out),
      .serial_write_oe(serial_write_oe), .serial_read_out(serial_read_out),
      .page_access(page_access), .page_access_valid(page_access_valid),
      .page_read_data(page_read_data), .page_pointer(page_pointer),
      .three_wire_mode(three_wire_mode),
      .master_page_selected(master_page_selected),
      .converter_page_selected(converter_page_selected),
      .sysref_power_down(sysref_power_down),
      .global_power_down(global_power_down),
      .soft_reset_pulse(soft_reset_pulse));
   spi_host_model host (.shift_clk(shift_clk),
      .serial_select_low(serial_select_low), .host_data(host_data),
      .data_pin(serial_write_in), .read_pin(serial_read_out));

   always #50 ref_clk = ~ref_clk;

   // Record forwarded accesses and cut a hang short
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (page_access_valid === 1'b1)
      begin
         last_acc <= page_access;
         acc_count <= acc_count + 1;
      end
      if (soft_reset_pulse === 1'b1)
         pulses <= pulses + 1;
      if (cycles == TIMEOUT_CYC)
      begin
         num_errors = num_errors + 1;
         $display("FAIL at %0t: timeout", $time);
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] c, input logic [7:0] d);
      logic [7:0] r;
      host.xfer({c, d}, 24, 1'b0, r);
   endtask

   task automatic rd(input logic [15:0] c, input logic three,
                     input logic [7:0] exp);
      logic [7:0] r;
      host.xfer({c, 8'h00}, 24, three, r);
      chk(32'(r), 32'(exp), "readback");
   endtask

   // One new access since count n, fields as given
   task automatic acc(input int n, input logic w, input page_e p,
                      input logic care, input logic cb,
                      input logic [11:0] a, input logic [7:0] d);
      chk(32'(acc_count), 32'(n + 1), "access count");
      chk(32'({last_acc.write, last_acc.page, last_acc.addr, last_acc.data}),
         32'({w, p, a, d}), "access");
      if (care)
         chk(32'(last_acc.chan_b), 32'(cb), "channel");
   endtask

   initial
   begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      chk(32'({page_pointer, master_page_selected, converter_page_selected}),
         32'h0, "reset state");
      // Every digital page: select, write, then two reads
      for (int i = 0; i < 7; i++)
      begin
         wr(16'h4004, PTRS[i][23:16]);
         wr(16'h4003, PTRS[i][15:8]);
         wr(16'h4002, PTRS[i][7:0]);
         chk(32'(page_pointer), 32'(PTRS[i]), "pointer");
         n = acc_count;
         wr(16'h60A6, 8'h30 + 8'(i));
         acc(n, 1'b1, PAGES[i], 1'b1, (i == 6) | PTRS[i][8], 12'h0A6,
            8'h30 + 8'(i));
         for (int k = 0; k < 2; k++)
         begin
            @(posedge ref_clk) page_read_data <= 8'hA0 + 8'(i * 2 + k);
            n = acc_count;
            rd(16'hE0A2, 1'b0, 8'hA0 + 8'(i * 2 + k));
            acc(n, 1'b0, PAGES[i], 1'b1, (i == 6) | PTRS[i][8], 12'h0A2,
               8'h00);
         end
      end
      n = acc_count;
      wr(16'h7001, 8'h5E);
      acc(n, 1'b1, PAGE_LINK, 1'b1, 1'b0, 12'h001, 8'h5E);
      // Direct pages need no pointer
      for (int i = 0; i < 4; i++)
      begin
         cmd = {DIRS[i], 8'h01};
         n = acc_count;
         wr(cmd, 8'h02);
         acc(n, 1'b1, cmd[10] ? PAGE_POWER : PAGE_DECIM, 1'b1, cmd[11],
            cmd[11:0], 8'h02);
      end
      host.xfer(24'h400412, 20, 1'b0, cmd[7:0]);
      chk(32'(page_pointer), 32'h690000, "short frame");
      // Analog bank selection and general registers
      wr(16'h0012, 8'h04);
      chk(32'(master_page_selected), 32'h1, "master sel");
      rd(16'h8012, 1'b0, 8'h04);
      wr(16'h0020, 8'h11);
      chk(32'({sysref_power_down, global_power_down}), 32'h3, "pdn");
      rd(16'h8020, 1'b0, 8'h11);
      n = acc_count;
      wr(16'h0030, 8'h33);
      acc(n, 1'b1, PAGE_MASTER, 1'b0, 1'b0, 12'h030, 8'h33);
      wr(16'h0012, 8'h00);
      wr(16'h0011, 8'hFF);
      n = acc_count;
      wr(16'h003F, 8'h44);
      acc(n, 1'b1, PAGE_CONVERTER, 1'b0, 1'b0, 12'h03F, 8'h44);
      wr(16'h0010, 8'h01);
      chk(32'(three_wire_mode), 32'h1, "wires");
      rd(16'h8011, 1'b1, 8'hFF);
      wr(16'h0000, 8'h01);
      chk(32'({page_pointer, converter_page_selected, three_wire_mode,
         sysref_power_down, global_power_down}), 32'h0,
         "soft reset");
      chk(32'(pulses), 32'h1, "soft pulse");
      wrap_up();
   end
endmodule

bind paged_spi_register_access paged_spi_sva u_sva (.*);

`default_nettype wire
